// ### src/cios_pkg.sv
package cios_pkg;

  // ****************************************
  // Bus and register map
  // ****************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] OFF_LINE_CFG = 8'h00;
  localparam logic [7:0] OFF_USER_VALUE = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_DELAY0 = 8'h10;
  localparam logic [7:0] OFF_DURATION0 = 8'h20;
  localparam logic [7:0] OFF_STRIDE = 8'h04;

  // ****************************************
  // Field layout
  // ****************************************
  localparam int NUM_LINES = 3;
  localparam int USER_W = 3;
  localparam int CFG_FIELD_W = 4;
  localparam int CFG_MODE_POS = 0;
  localparam int CFG_INVERT_POS = 2;
  localparam int CFG_PREDELAY_POS = 3;
  localparam int CFG_DIR_POS = 12;
  localparam int STAT_RUN_POS = 0;
  localparam int STAT_GO_POS = 1;
  localparam int STAT_LINE_POS = 4;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [1:0] RST_MODE = 2'h0;
  localparam logic RST_INVERT = 1'b0;
  localparam logic RST_PREDELAY = 1'b0;
  localparam logic [1:0] RST_DIR = 2'h0;
  localparam logic [2:0] RST_USER = 3'h0;
  localparam logic [22:0] RST_TIME = 23'h000000;

  // ****************************************
  // Timing
  // ****************************************
  localparam int TIME_W = 23;
  localparam int ELAPSED_W = 25;
  localparam logic [22:0] MAX_TIME_US = 23'd5000000;
  localparam int CLK_PERIOD_NS = 25;
  localparam int TIMEBASE_NS = 1000;
  localparam int CYCLES_PER_US = TIMEBASE_NS / CLK_PERIOD_NS;
  localparam int PRESC_W = 6;
  localparam logic [5:0] PRESC_LAST = 6'(CYCLES_PER_US - 1);

  // ****************************************
  // Output source selection
  // ****************************************
  typedef enum logic [1:0] {
    CIOS_SRC_TRIG_WAIT = 2'b00,
    CIOS_SRC_EXPOSURE = 2'b01,
    CIOS_SRC_STROBE = 2'b10,
    CIOS_SRC_USER = 2'b11
  } cios_mode_e;

endpackage : cios_pkg

// ### src/camera_io_output_strobe.sv
// Our own choices: the address map and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module cios_camera_io_output_strobe (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Register port
  input wire logic [cios_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [cios_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [cios_pkg::DATA_W-1:0] reg_rdata,
  // Sequencer side
  input wire logic frame_trig_wait,
  input wire logic exposure_active,
  input wire logic exposure_req,
  output logic exposure_go,
  // Lines
  output logic isolated_out,
  output logic general_line_a_out,
  output logic general_line_a_oe,
  output logic general_line_b_out,
  output logic general_line_b_oe
);
  import cios_pkg::*;

  // ****************************************
  // Configuration registers
  // ****************************************
  logic [1:0] line_mode [NUM_LINES];
  logic line_invert [NUM_LINES];
  logic line_predelay [NUM_LINES];
  logic [TIME_W-1:0] strobe_delay [NUM_LINES];
  logic [TIME_W-1:0] strobe_duration [NUM_LINES];
  logic [1:0] line_dir;
  logic [USER_W-1:0] user_value;

  // ****************************************
  // Run state
  // ****************************************
  logic running;
  logic go_done;
  logic [PRESC_W-1:0] presc;
  logic [ELAPSED_W-1:0] elapsed;
  logic [NUM_LINES-1:0] line_q;

  // ****************************************
  // Write decode
  // ****************************************
  wire sel_cfg = reg_wr && (reg_addr == OFF_LINE_CFG);
  wire sel_user = reg_wr && (reg_addr == OFF_USER_VALUE);
  wire [TIME_W-1:0] wr_time = (reg_wdata > DATA_W'(MAX_TIME_US)) ? MAX_TIME_US
                                                                : reg_wdata[TIME_W-1:0];
  wire tick = (presc == PRESC_LAST);

  // ****************************************
  // Per-line timing and source
  // ****************************************
  logic [ELAPSED_W-1:0] lead [NUM_LINES];
  logic [ELAPSED_W-1:0] rise [NUM_LINES];
  logic [ELAPSED_W-1:0] fall [NUM_LINES];
  logic [NUM_LINES-1:0] strobe_on;
  logic [NUM_LINES-1:0] next_line;
  logic [NUM_LINES-1:0] is_strobe;
  logic [ELAPSED_W-1:0] max_lead;
  logic [ELAPSED_W-1:0] max_fall_01;
  logic [ELAPSED_W-1:0] max_fall;
  logic [ELAPSED_W-1:0] max_lead_01;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_LINES; gi++) begin : g_line
      wire sel_delay = reg_wr && (reg_addr == 8'(OFF_DELAY0 + gi * OFF_STRIDE));
      wire sel_dur = reg_wr && (reg_addr == 8'(OFF_DURATION0 + gi * OFF_STRIDE));
      wire [ELAPSED_W-1:0] dly = {2'h0, strobe_delay[gi]};
      wire [ELAPSED_W-1:0] dur = {2'h0, strobe_duration[gi]};
      wire [CFG_FIELD_W-1:0] fld = reg_wdata[gi*CFG_FIELD_W +: CFG_FIELD_W];
      logic src;

      assign is_strobe[gi] = (line_mode[gi] == CIOS_SRC_STROBE);
      // Pre-delay strobe lines push the exposure start back by the largest of their delays
      assign lead[gi] = (is_strobe[gi] && line_predelay[gi]) ? dly : '0;
      assign rise[gi] = line_predelay[gi] ? (max_lead - dly) : (max_lead + dly);
      assign fall[gi] = rise[gi] + dur;
      assign strobe_on[gi] = running && is_strobe[gi] && (elapsed >= rise[gi])
                             && (elapsed < fall[gi]);

      always_comb begin
        case (line_mode[gi])
          CIOS_SRC_TRIG_WAIT: src = frame_trig_wait;
          CIOS_SRC_EXPOSURE: src = exposure_active;
          CIOS_SRC_STROBE: src = strobe_on[gi];
          default: src = user_value[gi];
        endcase
      end
      assign next_line[gi] = src ^ line_invert[gi];

      always_ff @(posedge core_clk) begin
        if (!rst_b) begin
          line_mode[gi] <= RST_MODE;
          line_invert[gi] <= RST_INVERT;
          line_predelay[gi] <= RST_PREDELAY;
          strobe_delay[gi] <= RST_TIME;
          strobe_duration[gi] <= RST_TIME;
        end else begin
          if (sel_cfg) begin
            line_mode[gi] <= fld[CFG_MODE_POS +: 2];
            line_invert[gi] <= fld[CFG_INVERT_POS];
            line_predelay[gi] <= fld[CFG_PREDELAY_POS];
          end
          if (sel_delay) begin
            strobe_delay[gi] <= wr_time;
          end
          if (sel_dur) begin
            strobe_duration[gi] <= wr_time;
          end
        end
      end
    end
  endgenerate

  // ****************************************
  // Shared run window
  // ****************************************
  assign max_lead_01 = (lead[0] > lead[1]) ? lead[0] : lead[1];
  assign max_lead = (max_lead_01 > lead[2]) ? max_lead_01 : lead[2];
  wire [ELAPSED_W-1:0] f0 = is_strobe[0] ? fall[0] : '0;
  wire [ELAPSED_W-1:0] f1 = is_strobe[1] ? fall[1] : '0;
  wire [ELAPSED_W-1:0] f2 = is_strobe[2] ? fall[2] : '0;
  assign max_fall_01 = (f0 > f1) ? f0 : f1;
  assign max_fall = (max_fall_01 > f2) ? max_fall_01 : f2;

  wire start_run = exposure_req && !running;
  wire next_go = running && !go_done && (elapsed == max_lead);
  wire run_over = go_done && (elapsed >= max_fall);

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      running <= 1'b0;
      go_done <= 1'b0;
      presc <= '0;
      elapsed <= '0;
      exposure_go <= 1'b0;
    end else begin
      exposure_go <= next_go;
      if (start_run) begin
        running <= 1'b1;
        go_done <= 1'b0;
        presc <= '0;
        elapsed <= '0;
      end else if (running) begin
        if (next_go) begin
          go_done <= 1'b1;
        end
        if (run_over) begin
          running <= 1'b0;
        end
        presc <= tick ? '0 : presc + 6'h01;
        if (tick) begin
          elapsed <= elapsed + 25'h0000001;
        end
      end
    end
  end

  // ****************************************
  // Shared control and line outputs
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      line_dir <= RST_DIR;
      user_value <= RST_USER;
      line_q <= '0;
    end else begin
      if (sel_cfg) begin
        line_dir <= reg_wdata[CFG_DIR_POS +: 2];
      end
      if (sel_user) begin
        user_value <= reg_wdata[USER_W-1:0];
      end
      line_q <= next_line;
    end
  end

  assign isolated_out = line_q[0];
  assign general_line_a_out = line_q[1];
  assign general_line_b_out = line_q[2];

  logic oe_a;
  logic oe_b;
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      oe_a <= 1'b0;
      oe_b <= 1'b0;
    end else begin
      oe_a <= line_dir[0];
      oe_b <= line_dir[1];
    end
  end
  assign general_line_a_oe = oe_a;
  assign general_line_b_oe = oe_b;

  // ****************************************
  // Read path
  // ****************************************
  logic [DATA_W-1:0] rd_mux;
  logic [DATA_W-1:0] cfg_word;
  logic [DATA_W-1:0] stat_word;

  always_comb begin
    cfg_word = '0;
    for (int i = 0; i < NUM_LINES; i++) begin
      cfg_word[i*CFG_FIELD_W + CFG_MODE_POS +: 2] = line_mode[i];
      cfg_word[i*CFG_FIELD_W + CFG_INVERT_POS] = line_invert[i];
      cfg_word[i*CFG_FIELD_W + CFG_PREDELAY_POS] = line_predelay[i];
    end
    cfg_word[CFG_DIR_POS +: 2] = line_dir;
  end

  always_comb begin
    stat_word = '0;
    stat_word[STAT_RUN_POS] = running;
    stat_word[STAT_GO_POS] = go_done;
    stat_word[STAT_LINE_POS +: NUM_LINES] = line_q;
  end

  always_comb begin
    if (reg_addr == OFF_LINE_CFG) begin
      rd_mux = cfg_word;
    end else if (reg_addr == OFF_USER_VALUE) begin
      rd_mux = {29'h00000000, user_value};
    end else if (reg_addr == OFF_STATUS) begin
      rd_mux = stat_word;
    end else if (reg_addr == OFF_DELAY0) begin
      rd_mux = {9'h000, strobe_delay[0]};
    end else if (reg_addr == 8'(OFF_DELAY0 + OFF_STRIDE)) begin
      rd_mux = {9'h000, strobe_delay[1]};
    end else if (reg_addr == 8'(OFF_DELAY0 + 2 * OFF_STRIDE)) begin
      rd_mux = {9'h000, strobe_delay[2]};
    end else if (reg_addr == OFF_DURATION0) begin
      rd_mux = {9'h000, strobe_duration[0]};
    end else if (reg_addr == 8'(OFF_DURATION0 + OFF_STRIDE)) begin
      rd_mux = {9'h000, strobe_duration[1]};
    end else if (reg_addr == 8'(OFF_DURATION0 + 2 * OFF_STRIDE)) begin
      rd_mux = {9'h000, strobe_duration[2]};
    end else begin
      rd_mux = '0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : '0;
    end
  end

endmodule : cios_camera_io_output_strobe
`default_nettype wire

// ### tb/cios_checker.sv
`timescale 1ns/10ps
`default_nettype none
// ****
// Port checker
// ****
module cios_checker (
  // Bus
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // Sequencer and lines
  input wire logic frame_trig_wait,
  input wire logic exposure_active,
  input wire logic exposure_go,
  input wire logic isolated_out,
  input wire logic general_line_a_out,
  input wire logic general_line_a_oe,
  input wire logic general_line_b_out,
  input wire logic general_line_b_oe
);
  import cios_pkg::*;
  logic [13:0] cfg;
  logic [2:0] usr;
  wire [2:0] outs = {general_line_b_out, general_line_a_out, isolated_out};
  wire [2:0] inv = {cfg[10], cfg[6], cfg[2]};
  wire [2:0] m_wait = {cfg[9:8] == 2'h0, cfg[5:4] == 2'h0, cfg[1:0] == 2'h0};
  wire [2:0] m_expo = {cfg[9:8] == 2'h1, cfg[5:4] == 2'h1, cfg[1:0] == 2'h1};
  wire [2:0] m_user = {cfg[9:8] == 2'h3, cfg[5:4] == 2'h3, cfg[1:0] == 2'h3};
  // Shadow of the settings seen on the bus
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      cfg <= 14'h0000;
      usr <= 3'h0;
    end else if (reg_wr && reg_addr == OFF_LINE_CFG) begin
      cfg <= reg_wdata[13:0];
    end else if (reg_wr && reg_addr == OFF_USER_VALUE) begin
      usr <= reg_wdata[2:0];
    end
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  sequence s_go;
    exposure_go ##1 !exposure_go;
  endsequence
  property p_rd_zero;
    !reg_rd |=> reg_rdata == 32'h00000000;
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("rdata not idle");
  property p_rd_user;
    reg_rd && reg_addr == OFF_USER_VALUE |=> reg_rdata == {29'h0, usr};
  endproperty
  a_rd_user: assert property (p_rd_user) else $error("user value read");
  property p_rd_cfg;
    reg_rd && reg_addr == OFF_LINE_CFG |=> reg_rdata[13:0] == cfg;
  endproperty
  a_rd_cfg: assert property (p_rd_cfg) else $error("line cfg read");
  property p_go;
    exposure_go |-> s_go;
  endproperty
  a_go: assert property (p_go) else $error("go not a pulse");
  property p_wait;
    1'b1 |=> ((outs ^ $past(inv) ^ {3{$past(frame_trig_wait)}}) & $past(m_wait)) == 3'h0;
  endproperty
  a_wait: assert property (p_wait) else $error("wait source");
  property p_expo;
    1'b1 |=> ((outs ^ $past(inv) ^ {3{$past(exposure_active)}}) & $past(m_expo)) == 3'h0;
  endproperty
  a_expo: assert property (p_expo) else $error("exposure source");
  property p_user;
    1'b1 |=> ((outs ^ $past(inv) ^ $past(usr)) & $past(m_user)) == 3'h0;
  endproperty
  a_user: assert property (p_user) else $error("user source");
  property p_oe;
    1'b1 |=> {general_line_b_oe, general_line_a_oe} == $past(cfg[13:12]);
  endproperty
  a_oe: assert property (p_oe) else $error("line enable");
endmodule : cios_checker
bind cios_camera_io_output_strobe cios_checker cios_checker_inst (.core_clk, .rst_b,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .frame_trig_wait, .exposure_active,
  .exposure_go, .isolated_out, .general_line_a_out, .general_line_a_oe, .general_line_b_out,
  .general_line_b_oe);
`default_nettype wire

// ### tb/cios_lamp.sv
`timescale 1ns/10ps
`default_nettype none
// ****
// Flash lamp on the three lines
// ****
module cios_lamp (
  // Clock and time
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [31:0] cyc,
  // Pin levels
  input wire logic [2:0] pin_lvl,
  // Flash log
  output logic [31:0] rise_t [3],
  output logic [31:0] fall_t [3],
  output logic [7:0] flashes [3]
);
  logic [2:0] last;
  always @(posedge core_clk) begin
    last <= pin_lvl;
    for (int i = 0; i < 3; i++) begin
      if (!rst_b) begin
        flashes[i] <= 8'h00;
      end else if (pin_lvl[i] && !last[i]) begin
        rise_t[i] <= cyc;
        flashes[i] <= flashes[i] + 8'h01;
      end else if (!pin_lvl[i] && last[i]) begin
        fall_t[i] <= cyc;
      end
    end
  end
endmodule : cios_lamp
`default_nettype wire

// ### tb/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
// ****
// Bench
// ****
module tb_top;
  import cios_pkg::*;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic frame_trig_wait = 1'b0;
  logic exposure_active = 1'b0;
  logic exposure_req = 1'b0;
  logic [31:0] cyc = 32'h0;
  logic [31:0] gos = 32'h0;
  logic [31:0] go_t, reg_rdata;
  logic [31:0] rise_t [3];
  logic [31:0] fall_t [3];
  logic [7:0] flashes [3];
  // Flash counts before the strobe runs
  logic [7:0] fl_base [2];
  logic exposure_go, isolated_out, general_line_a_out, general_line_a_oe;
  logic general_line_b_out, general_line_b_oe;
  int mismatches = 0;
  int total_checks = 0;
  // Wait level, exposure level, user value, expected pins
  logic [7:0] tv [3] = '{8'hA5, 8'h4A, 8'h3C};
  // Pins pulled down while not driven
  wire [2:0] pin_lvl = {general_line_b_oe & general_line_b_out,
    general_line_a_oe & general_line_a_out, isolated_out};
  cios_camera_io_output_strobe cios_camera_io_output_strobe_inst (.core_clk, .rst_b, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .frame_trig_wait, .exposure_active, .exposure_req,
    .exposure_go, .isolated_out, .general_line_a_out, .general_line_a_oe, .general_line_b_out,
    .general_line_b_oe);
  cios_lamp cios_lamp_inst (.core_clk, .rst_b, .cyc, .pin_lvl, .rise_t, .fall_t, .flashes);
  initial begin
    forever #12.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 32'h1;
    if (exposure_go === 1'b1) begin
      go_t <= cyc;
      gos <= gos + 32'h1;
    end
  end
  task automatic end_of_test;
    if (mismatches == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #2;
    chk(reg_rdata, e);
    @(posedge core_clk);
  endtask : rd
  task automatic see(input logic [2:0] e);
    #2;
    chk({29'h0, pin_lvl}, {29'h0, e});
    @(posedge core_clk);
  endtask : see
  task automatic run;
    exposure_req <= 1'b1;
    @(posedge core_clk);
    exposure_req <= 1'b0;
    repeat (300) @(posedge core_clk);
  endtask : run
  // One when d lies within one cycle of w
  function automatic logic [31:0] near(input logic [31:0] d, input logic [31:0] w);
    return {31'h0, d + 32'h1 - w <= 32'h2};
  endfunction : near
  initial begin
    repeat (5000) @(posedge core_clk);
    mismatches++;
    end_of_test;
  end
  initial begin
    repeat (6) @(posedge core_clk);
    rst_b <= 1'b1;
    rd(OFF_LINE_CFG, 32'h0);
    wr(OFF_LINE_CFG, 32'h00003333);
    wr(OFF_USER_VALUE, 32'hFFFFFFF9);
    see(3'h1);
    rd(OFF_USER_VALUE, 32'h1);
    wr(OFF_LINE_CFG, 32'h00003373);
    see(3'h3);
    wr(OFF_LINE_CFG, 32'h00003310);
    for (int i = 0; i < 3; i++) begin
      frame_trig_wait <= tv[i][7];
      exposure_active <= tv[i][6];
      wr(OFF_USER_VALUE, {29'h0, tv[i][5:3]});
      see(tv[i][2:0]);
    end
    wr(OFF_LINE_CFG, 32'h00003222);
    wr(OFF_DELAY0, 32'h2);
    wr(OFF_DURATION0, 32'h3);
    wr(OFF_DELAY0 + 8'h08, 32'h1);
    wr(OFF_DURATION0 + 8'h08, 32'h1);
    fl_base[0] = flashes[0];
    fl_base[1] = flashes[1];
    run;
    chk(near(rise_t[0] - go_t, 32'd80), 32'h1);
    chk(fall_t[0] - rise_t[0], 32'd120);
    chk(near(rise_t[2] - go_t, 32'd40), 32'h1);
    chk(fall_t[2] - rise_t[2], 32'd40);
    chk({24'h0, flashes[1] - fl_base[1]}, 32'h0);
    wr(OFF_LINE_CFG, 32'h0000332A);
    wr(OFF_DELAY0, 32'h3);
    wr(OFF_DURATION0, 32'h2);
    wr(OFF_DELAY0 + 8'h04, 32'h1);
    wr(OFF_DURATION0 + 8'h04, 32'h1);
    exposure_req <= 1'b1;
    repeat (20) @(posedge core_clk);
    run;
    chk(near(go_t - rise_t[0], 32'd120), 32'h1);
    chk(fall_t[0] - rise_t[0], 32'd80);
    chk(near(rise_t[1] - go_t, 32'd40), 32'h1);
    chk(gos, 32'h2);
    chk({24'h0, flashes[0] - fl_base[0]}, 32'h2);
    rd(OFF_STATUS, 32'h00000042);
    wr(OFF_DELAY0 + 8'h08, 32'h00FFFFFF);
    rd(OFF_DELAY0 + 8'h08, 32'h004C4B40);
    wr(OFF_DURATION0, 32'h007FFFFF);
    rd(OFF_DURATION0, 32'h004C4B40);
    end_of_test;
  end
endmodule : tb_top
`default_nettype wire
